// file: hw/fsr_pkg.sv
/*
  shared constants for the fault flag and stagger register bank: register indices,
  field positions, reset values, load thresholds and encodings.
  assumes nothing of its surroundings; imported by every design file.
*/
package fsr_pkg;
  // register indices as seen by the serial register port
  localparam logic [7:0] FSR_ADDR_FAULT = 8'h05;
  localparam logic [7:0] FSR_ADDR_STEP = 8'h06;
  localparam int FSR_DATA_W = 16;
  localparam int FSR_NUM_CH = 8;

  // fault register layout
  localparam int FSR_BIT_THERMAL = 4;
  localparam int FSR_BIT_OVERCURRENT = 3;
  localparam int FSR_BIT_OVERVOLTAGE = 2;
  localparam int FSR_BIT_STRING_OPEN = 1;
  localparam int FSR_BIT_STRING_SHORT = 0;
  localparam int FSR_NUM_FLAGS = 5;
  localparam int FSR_ID_LSB = 8;
  localparam logic [4:0] FSR_FLAGS_RESET = 5'h00;
  localparam logic [2:0] FSR_FAULT_RSVD = 3'h0;
  // arbitrary identifier value, not tied to any real part
  localparam logic [7:0] FSR_PART_ID_DEFAULT = 8'h5a;

  // stepping and stagger register layout
  localparam int FSR_STEP_LSB = 2;
  localparam int FSR_STAGGER_LSB = 0;
  localparam logic [15:0] FSR_STEP_REG_RESET = 16'h0000;

  // load-based stepping codes
  localparam logic [2:0] FSR_STEP_OFF = 3'h0;
  localparam logic [2:0] FSR_STEP_10_5 = 3'h1;
  localparam logic [2:0] FSR_STEP_8_3 = 3'h2;
  localparam logic [2:0] FSR_STEP_5_2 = 3'h3;

  // load thresholds, in microamps of led current
  localparam logic [15:0] FSR_TH_HI_10MA_UA = 16'h2710; // 10 mA
  localparam logic [15:0] FSR_TH_LO_5MA_UA = 16'h1388; // 5 mA
  localparam logic [15:0] FSR_TH_HI_8MA_UA = 16'h1f40; // 8 mA
  localparam logic [15:0] FSR_TH_LO_3MA_UA = 16'h0bb8; // 3 mA
  localparam logic [15:0] FSR_TH_HI_5MA_UA = 16'h1388; // 5 mA
  localparam logic [15:0] FSR_TH_LO_2MA_UA = 16'h07d0; // 2 mA

  // stagger codes
  localparam logic [1:0] FSR_STAGGER_NONE = 2'h0;
  localparam logic [1:0] FSR_STAGGER_EACH = 2'h1;
  localparam logic [1:0] FSR_STAGGER_PAIRS = 2'h2;
  localparam logic [1:0] FSR_STAGGER_HALVES = 2'h3;

  // frequency choice handed to the boost loop
  typedef enum logic [1:0] {
    FSR_FREQ_FIXED = 2'h0,
    FSR_FREQ_350K = 2'h1,
    FSR_FREQ_650K = 2'h2,
    FSR_FREQ_1M2 = 2'h3
  } fsr_freq_t;
endpackage

// file: hw/fsr_stagger_phase.sv
/*
  per-channel phase offset generator for pulse dimming stagger.
  assumes one period_start pulse per dimming period and a stable period length.
*/
`timescale 1ns/10ps
module fsr_stagger_phase #(
  parameter int NUM_CH = fsr_pkg::FSR_NUM_CH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic period_start,
  input wire logic [15:0] period_cycles,
  input wire logic [1:0] stagger_mode,
  input wire logic pwm_dim_active,
  output logic [NUM_CH-1:0] chan_start
);
  import fsr_pkg::*;

  logic [15:0] cnt_reg;
  logic running_reg;
  logic [1:0] mode_reg;
  logic [15:0] cur_cnt;
  logic live;

  // mode is latched at the period boundary so a write mid-period cannot double-fire
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= FSR_STAGGER_NONE;
    end else if (period_start) begin
      mode_reg <= pwm_dim_active ? stagger_mode : FSR_STAGGER_NONE; // see R15
    end
  end

  // position inside the current dimming period
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      running_reg <= 1'b0;
    end else if (period_start) begin
      cnt_reg <= 16'h0000;
      running_reg <= (period_cycles > 16'h0001);
    end else if (running_reg) begin
      cnt_reg <= cnt_reg + 16'h0001;
      running_reg <= (cnt_reg + 16'h0002) < period_cycles;
    end
  end

  assign cur_cnt = period_start ? 16'h0000 : cnt_reg + 16'h0001;
  assign live = period_start | running_reg;

  // each channel fires once at its evenly spaced slot
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [2:0] slot;
    logic [1:0] shift;
    logic [18:0] prod;
    logic [15:0] offset;
    logic [1:0] eff_mode;
    always_comb begin
      eff_mode = period_start ? (pwm_dim_active ? stagger_mode : FSR_STAGGER_NONE) : mode_reg;
      case (eff_mode)
        FSR_STAGGER_EACH: begin // see R11
          slot = 3'(i);
          shift = 2'h3;
        end
        FSR_STAGGER_PAIRS: begin // see R12
          slot = 3'(i >> 1);
          shift = 2'h2;
        end
        FSR_STAGGER_HALVES: begin // see R13
          slot = 3'(i >> 2);
          shift = 2'h1;
        end
        default: begin
          slot = 3'h0;
          shift = 2'h0;
        end
      endcase
      prod = period_cycles * slot;
      offset = 16'(prod >> shift); // see R15
    end
    always_ff @(posedge core_clk) begin
      if (rst) begin
        chan_start[i] <= 1'b0;
      end else begin
        chan_start[i] <= live && (cur_cnt == offset);
      end
    end
  end
endmodule

// file: hw/fsr_bank.sv
/*
  fault flag register and load-based frequency stepping / stagger register of a
  backlight led driver, plus the logic those registers steer.
  assumes a word-wide register port from the serial interface engine, synchronous
  to core_clk, and protection events given as one-cycle or level pulses on core_clk.
*/
// How it works
// R1 - thermal shutdown event sets fault bit 4; it reads 0 otherwise.
// R2 - over-current event sets fault bit 3; it reads 0 otherwise.
// R3 - output over-voltage event sets fault bit 2; it reads 0 otherwise.
// R4 - open string on any sink sets fault bit 1; it reads 0 otherwise.
// R5 - shorted string sets fault bit 0; it reads 0 otherwise.
// R6 - flags latch until the fault register is read; all reset to zero.
// R7 - bits 4:2 choose load stepping; 000 off at reset, 100-111 reserved.
// R8 - code 001: above 10mA 1.2MHz, below 5mA 350kHz, else 650kHz.
// R9 - code 010: 650kHz from 8mA, 350kHz below 3mA.
// R10 - code 011: 650kHz from 5mA, 350kHz below 2mA.
// R11 - stagger bits 1:0: 00 no offset, 01 each channel own phase.
// R12 - code 10: channel pairs switch together, four pairs staggered.
// R13 - code 11: channels 1-4 and 5-8 grouped, two groups staggered.
// R14 - fault register bits 15:8 hold part identifier; bits 7:5 read zero.
// R15 - offsets evenly spread over one dimming period, only during pulse dimming.
`timescale 1ns/10ps
module fsr_bank #(
  parameter logic [7:0] PART_ID = fsr_pkg::FSR_PART_ID_DEFAULT, // arbitrary value
  parameter int NUM_CH = fsr_pkg::FSR_NUM_CH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [fsr_pkg::FSR_DATA_W-1:0] reg_wdata,
  output logic [fsr_pkg::FSR_DATA_W-1:0] reg_rdata,
  input wire logic thermal_event,
  input wire logic over_current_protection,
  input wire logic output_over_voltage_protection,
  input wire logic [NUM_CH-1:0] string_open_event,
  input wire logic string_short_event,
  input wire logic [15:0] led_current_ua,
  input wire logic pwm_dim_active,
  input wire logic dim_period_start,
  input wire logic [15:0] dim_period_cycles,
  output fsr_pkg::fsr_freq_t freq_select,
  output logic [NUM_CH-1:0] chan_start,
  output logic thermal_fault_flag,
  output logic overcurrent_fault_flag,
  output logic overvoltage_fault_flag,
  output logic string_open_fault_flag,
  output logic string_short_fault_flag
);
  import fsr_pkg::*;

  logic [FSR_NUM_FLAGS-1:0] flags_reg;
  logic [FSR_NUM_FLAGS-1:0] flags_next;
  logic [FSR_NUM_FLAGS-1:0] flag_events;
  logic [15:0] step_reg;
  logic [2:0] load_based_freq_step;
  logic [1:0] channel_stagger_select;
  logic [7:0] part_identifier_field;
  logic fault_read;
  logic step_write;
  fsr_freq_t freq_next;

  assign part_identifier_field = PART_ID; // see R14
  assign fault_read = reg_rd && (reg_addr == FSR_ADDR_FAULT);
  assign step_write = reg_wr && (reg_addr == FSR_ADDR_STEP);
  assign load_based_freq_step = step_reg[FSR_STEP_LSB +: 3];
  assign channel_stagger_select = step_reg[FSR_STAGGER_LSB +: 2];

  // gather raw protection events into flag positions
  always_comb begin
    flag_events = '0;
    flag_events[FSR_BIT_THERMAL] = thermal_event; // see R1
    flag_events[FSR_BIT_OVERCURRENT] = over_current_protection; // see R2
    flag_events[FSR_BIT_OVERVOLTAGE] = output_over_voltage_protection; // see R3
    flag_events[FSR_BIT_STRING_OPEN] = |string_open_event; // see R4
    flag_events[FSR_BIT_STRING_SHORT] = string_short_event; // see R5
  end

  // clear-on-read; an event in the read cycle re-sets so it is never lost
  assign flags_next = (flags_reg & ~{FSR_NUM_FLAGS{fault_read}}) | flag_events; // see R6

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_reg <= FSR_FLAGS_RESET; // see R6
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign thermal_fault_flag = flags_reg[FSR_BIT_THERMAL];
  assign overcurrent_fault_flag = flags_reg[FSR_BIT_OVERCURRENT];
  assign overvoltage_fault_flag = flags_reg[FSR_BIT_OVERVOLTAGE];
  assign string_open_fault_flag = flags_reg[FSR_BIT_STRING_OPEN];
  assign string_short_fault_flag = flags_reg[FSR_BIT_STRING_SHORT];

  // stepping/stagger register; reserved upper bits are kept as written
  always_ff @(posedge core_clk) begin
    if (rst) begin
      step_reg <= FSR_STEP_REG_RESET; // see R7
    end else if (step_write) begin
      step_reg <= reg_wdata;
    end
  end

  // read data is registered; the flags shown are the ones being cleared
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        FSR_ADDR_FAULT: begin
          reg_rdata <= {part_identifier_field, FSR_FAULT_RSVD, flags_reg}; // see R14
        end
        FSR_ADDR_STEP: begin
          reg_rdata <= step_reg;
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end
  end

  // load-based frequency choice; reserved codes behave as disabled
  always_comb begin
    case (load_based_freq_step)
      FSR_STEP_10_5: begin // see R8
        if (led_current_ua > FSR_TH_HI_10MA_UA) begin
          freq_next = FSR_FREQ_1M2;
        end else if (led_current_ua < FSR_TH_LO_5MA_UA) begin
          freq_next = FSR_FREQ_350K;
        end else begin
          freq_next = FSR_FREQ_650K;
        end
      end
      FSR_STEP_8_3: begin // see R9
        if (led_current_ua < FSR_TH_LO_3MA_UA) begin
          freq_next = FSR_FREQ_350K;
        end else begin
          freq_next = FSR_FREQ_650K;
        end
      end
      FSR_STEP_5_2: begin // see R10
        if (led_current_ua < FSR_TH_LO_2MA_UA) begin
          freq_next = FSR_FREQ_350K;
        end else begin
          freq_next = FSR_FREQ_650K;
        end
      end
      default: begin
        freq_next = FSR_FREQ_FIXED; // see R7
      end
    endcase
  end

  // registered so the boost loop never sees a decode glitch
  always_ff @(posedge core_clk) begin
    if (rst) begin
      freq_select <= FSR_FREQ_FIXED;
    end else begin
      freq_select <= freq_next;
    end
  end

  // channel phase generator; stagger only applies while pulse dimming runs
  fsr_stagger_phase #(
    .NUM_CH(NUM_CH)
  ) u_phase (
    .core_clk(core_clk),
    .rst(rst),
    .period_start(dim_period_start),
    .period_cycles(dim_period_cycles),
    .stagger_mode(channel_stagger_select),
    .pwm_dim_active(pwm_dim_active),
    .chan_start(chan_start)
  );

  // checks kept beside the logic they guard
  sequence s_fault_read_quiet;
    fault_read && !thermal_event;
  endsequence

  sequence s_read_no_event;
    fault_read && !(|flag_events);
  endsequence

  a_thermal_sets: assert property (@(posedge core_clk) disable iff (rst) // see R1
    thermal_event |=> thermal_fault_flag [*1])
    else $error("thermal flag not set after event");

  a_overcurrent_sets: assert property (@(posedge core_clk) disable iff (rst) // see R2
    over_current_protection |=> overcurrent_fault_flag)
    else $error("overcurrent flag not set after event");

  a_overvolt_sets: assert property (@(posedge core_clk) disable iff (rst) // see R3
    output_over_voltage_protection |=> overvoltage_fault_flag)
    else $error("overvoltage flag not set after event");

  a_open_any_sets: assert property (@(posedge core_clk) disable iff (rst) // see R4
    (|string_open_event) |=> string_open_fault_flag)
    else $error("open string flag not set");

  a_short_sets: assert property (@(posedge core_clk) disable iff (rst) // see R5
    string_short_event |=> string_short_fault_flag)
    else $error("short string flag not set");

  a_flag_holds: assert property (@(posedge core_clk) disable iff (rst) // see R6
    thermal_fault_flag && !fault_read |=> thermal_fault_flag)
    else $error("thermal flag dropped without a read");

  a_read_clears: assert property (@(posedge core_clk) disable iff (rst) // see R6
    s_fault_read_quiet |=> !thermal_fault_flag)
    else $error("thermal flag not cleared by read");

  a_flag_no_spur: assert property (@(posedge core_clk) disable iff (rst) // see R1
    !thermal_fault_flag && !thermal_event |=> !thermal_fault_flag)
    else $error("thermal flag set without an event");

  a_fault_readback: assert property (@(posedge core_clk) disable iff (rst) // see R14
    fault_read |=> reg_rdata == {PART_ID, 3'h0, $past(flags_reg)})
    else $error("fault register read data wrong");

  a_step_hi_load: assert property (@(posedge core_clk) disable iff (rst) // see R8
    load_based_freq_step == FSR_STEP_10_5 && led_current_ua > FSR_TH_HI_10MA_UA
    |=> freq_select == FSR_FREQ_1M2)
    else $error("high load did not pick top frequency");

  a_step_low_load: assert property (@(posedge core_clk) disable iff (rst) // see R9
    load_based_freq_step == FSR_STEP_8_3 && led_current_ua < FSR_TH_LO_3MA_UA
    |=> freq_select == FSR_FREQ_350K)
    else $error("light load did not pick low frequency");

  a_step_mid_load: assert property (@(posedge core_clk) disable iff (rst) // see R10
    load_based_freq_step == FSR_STEP_5_2 && led_current_ua >= FSR_TH_LO_2MA_UA
    |=> freq_select == FSR_FREQ_650K)
    else $error("mid load did not pick middle frequency");

  a_step_off: assert property (@(posedge core_clk) disable iff (rst) // see R7
    load_based_freq_step == FSR_STEP_OFF |=> freq_select == FSR_FREQ_FIXED)
    else $error("stepping active while disabled");

  a_step_write: assert property (@(posedge core_clk) disable iff (rst) // see R7
    step_write |=> step_reg == $past(reg_wdata))
    else $error("step register write lost");

  a_no_stagger: assert property (@(posedge core_clk) disable iff (rst) // see R15
    dim_period_start && !pwm_dim_active |=> chan_start == {NUM_CH{1'b1}})
    else $error("channels staggered outside pulse dimming");

  a_zero_offset: assert property (@(posedge core_clk) disable iff (rst) // see R11
    dim_period_start && pwm_dim_active && channel_stagger_select == FSR_STAGGER_NONE
    |=> chan_start == {NUM_CH{1'b1}})
    else $error("stagger code 00 applied an offset");

  a_pairs_together: assert property (@(posedge core_clk) disable iff (rst) // see R12
    dim_period_start && pwm_dim_active && channel_stagger_select == FSR_STAGGER_PAIRS
    |=> chan_start == {{(NUM_CH-2){1'b0}}, 2'b11})
    else $error("pair stagger first slot wrong");

  a_halves_together: assert property (@(posedge core_clk) disable iff (rst) // see R13
    dim_period_start && pwm_dim_active && channel_stagger_select == FSR_STAGGER_HALVES
    |=> chan_start == {{NUM_CH/2{1'b0}}, {NUM_CH/2{1'b1}}})
    else $error("half stagger first slot wrong");

  a_oc_holds: assert property (@(posedge core_clk) disable iff (rst) // see R6
    overcurrent_fault_flag && !fault_read |=> overcurrent_fault_flag)
    else $error("overcurrent flag dropped without a read");

  a_ov_holds: assert property (@(posedge core_clk) disable iff (rst) // see R6
    overvoltage_fault_flag && !fault_read |=> overvoltage_fault_flag)
    else $error("overvoltage flag dropped without a read");

  a_open_holds: assert property (@(posedge core_clk) disable iff (rst) // see R6
    string_open_fault_flag && !fault_read |=> string_open_fault_flag)
    else $error("open string flag dropped without a read");

  a_short_holds: assert property (@(posedge core_clk) disable iff (rst) // see R6
    string_short_fault_flag && !fault_read |=> string_short_fault_flag)
    else $error("short string flag dropped without a read");

  a_read_clears_all: assert property (@(posedge core_clk) disable iff (rst) // see R6
    s_read_no_event |=> flags_reg == FSR_FLAGS_RESET)
    else $error("fault read left a flag set");

  a_top_mid_load: assert property (@(posedge core_clk) disable iff (rst) // see R8
    load_based_freq_step == FSR_STEP_10_5 && led_current_ua <= FSR_TH_HI_10MA_UA
    && led_current_ua >= FSR_TH_LO_5MA_UA |=> freq_select == FSR_FREQ_650K)
    else $error("mid load on code 001 did not pick middle frequency");

  a_top_light_load: assert property (@(posedge core_clk) disable iff (rst) // see R8
    load_based_freq_step == FSR_STEP_10_5 && led_current_ua < FSR_TH_LO_5MA_UA
    |=> freq_select == FSR_FREQ_350K)
    else $error("light load on code 001 did not pick low frequency");

  a_step_8_3_mid: assert property (@(posedge core_clk) disable iff (rst) // see R9
    load_based_freq_step == FSR_STEP_8_3 && led_current_ua >= FSR_TH_LO_3MA_UA
    |=> freq_select == FSR_FREQ_650K)
    else $error("mid load on code 010 did not pick middle frequency");

  a_step_5_2_low: assert property (@(posedge core_clk) disable iff (rst) // see R10
    load_based_freq_step == FSR_STEP_5_2 && led_current_ua < FSR_TH_LO_2MA_UA
    |=> freq_select == FSR_FREQ_350K)
    else $error("light load on code 011 did not pick low frequency");

  a_step_reserved: assert property (@(posedge core_clk) disable iff (rst) // see R7
    load_based_freq_step[2] |=> freq_select == FSR_FREQ_FIXED)
    else $error("reserved stepping code changed frequency");

  a_each_first_slot: assert property (@(posedge core_clk) disable iff (rst) // see R11
    dim_period_start && pwm_dim_active && channel_stagger_select == FSR_STAGGER_EACH
    |=> chan_start == {{(NUM_CH-1){1'b0}}, 1'b1})
    else $error("per-channel stagger first slot wrong");

  a_step_holds: assert property (@(posedge core_clk) disable iff (rst) // see R7
    !step_write |=> $stable(step_reg))
    else $error("step register changed without a write");
endmodule

// file: bench/fsr_host_model.sv
/*
  host side of the word-wide register port: one write task and one read task.
  assumes the bank samples its strobes on the rising edge of core_clk and answers
  a read with data that stays put until the next read strobe.
*/
`timescale 1ns/10ps
module fsr_host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // idle bus at time zero, strobes low
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // one-cycle write strobe; address and data are scrambled afterwards so a
  // bank that samples late never sees a stale but plausible word
  task automatic wr_word(input logic [7:0] addr, input logic [15:0] data);
    @(negedge core_clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  // one-cycle read strobe, data taken a full cycle later where it is settled
  task automatic rd_word(input logic [7:0] addr, output logic [15:0] data);
    @(negedge core_clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    @(negedge core_clk);
    data = reg_rdata;
  endtask
endmodule

// file: bench/testbench.sv
/*
  self-checking bench for the fault flag and stepping/stagger register bank.
  assumes the host model above and the bank's one-cycle read and output latencies.
*/
`timescale 1ns/10ps
module testbench;
  import fsr_pkg::*;
  localparam logic [7:0] TB_PART_ID = 8'h3c; // arbitrary identifier value
  localparam int PER = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [4:0] ev = 5'h00;
  logic [7:0] open_mask = 8'h80;
  logic [15:0] led_current_ua = 16'h0000;
  logic pwm_dim_active = 1'b0;
  logic dim_period_start = 1'b0;
  logic [15:0] dim_period_cycles = 16'(PER);
  fsr_freq_t freq_select;
  logic [7:0] chan_start;
  wire logic [4:0] flags;
  int miscompares = 0;
  int check_count = 0;
  int ua_list[8] = '{1999, 2000, 2999, 3000, 4999, 5000, 10000, 10001};

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  fsr_bank #(.PART_ID(TB_PART_ID)) i_dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .thermal_event(ev[4]), .over_current_protection(ev[3]),
    .output_over_voltage_protection(ev[2]), .string_open_event({8{ev[1]}} & open_mask),
    .string_short_event(ev[0]), .led_current_ua(led_current_ua),
    .pwm_dim_active(pwm_dim_active), .dim_period_start(dim_period_start),
    .dim_period_cycles(dim_period_cycles), .freq_select(freq_select),
    .chan_start(chan_start), .thermal_fault_flag(flags[4]),
    .overcurrent_fault_flag(flags[3]), .overvoltage_fault_flag(flags[2]),
    .string_open_fault_flag(flags[1]), .string_short_fault_flag(flags[0])
  );

  fsr_host_model i_host (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  // compare tasks: register words and narrow outputs
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t register word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t output value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    i_host.rd_word(addr, d);
    cmp_reg(d, exp);
  endtask

  // expected frequency step from code and load current
  function automatic logic [1:0] exp_freq(input logic [2:0] c, input int ua);
    case (c)
      3'h1: return (ua > 10000) ? 2'h3 : ((ua < 5000) ? 2'h1 : 2'h2);
      3'h2: return (ua < 3000) ? 2'h1 : 2'h2;
      3'h3: return (ua < 2000) ? 2'h1 : 2'h2;
      default: return 2'h0;
    endcase
  endfunction

  // one dimming period: record first pulse cycle of every channel
  task automatic run_stagger(input logic [1:0] mode, input logic dim);
    int first[8];
    int off;
    first = '{default: 0};
    @(negedge core_clk);
    pwm_dim_active = dim;
    dim_period_start = 1'b1;
    // offset-0 channels already pulse on the first negedge after the start edge
    for (int n = 1; n <= 20; n++) begin
      @(negedge core_clk);
      dim_period_start = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (chan_start[i] === 1'b1 && first[i] == 0) first[i] = n;
      end
    end
    for (int i = 0; i < 8; i++) begin
      off = !dim ? 0 : (mode == 2'h1) ? PER * i / 8 : (mode == 2'h2) ? PER * (i / 2) / 4 :
            (mode == 2'h3) ? PER * (i / 4) / 2 : 0;
      cmp_out(8'(first[i]), 8'(off + 1));
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard: far beyond the length of the main sequence
  initial begin
    repeat (50000) @(posedge core_clk);
    miscompares++;
    stop_test;
  end

  // main sequence
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    cmp_out({3'h0, flags}, 8'h00);
    rd_chk(FSR_ADDR_FAULT, {TB_PART_ID, 8'h00});
    rd_chk(FSR_ADDR_STEP, 16'h0000);
    // each event alone: latches, survives idle cycles, cleared by one read
    for (int b = 0; b < 5; b++) begin
      @(negedge core_clk);
      ev[b] = 1'b1;
      @(negedge core_clk);
      ev[b] = 1'b0;
      cmp_out({3'h0, flags}, 8'h01 << b);
      repeat (3) @(negedge core_clk);
      cmp_out({3'h0, flags}, 8'h01 << b);
      rd_chk(FSR_ADDR_FAULT, {TB_PART_ID, 3'h0, 5'h01 << b});
      rd_chk(FSR_ADDR_FAULT, {TB_PART_ID, 8'h00});
    end
    // all events together, then an event held through a read wins over clearing
    @(negedge core_clk);
    ev = 5'h1f;
    @(negedge core_clk);
    ev = 5'h10;
    rd_chk(FSR_ADDR_FAULT, {TB_PART_ID, 8'h1f});
    rd_chk(FSR_ADDR_FAULT, {TB_PART_ID, 8'h10});
    @(negedge core_clk);
    ev = 5'h00;
    rd_chk(FSR_ADDR_FAULT, {TB_PART_ID, 8'h10});
    rd_chk(FSR_ADDR_FAULT, {TB_PART_ID, 8'h00});
    // read-only fault word, read/write step word, unmapped index reads zero
    i_host.wr_word(FSR_ADDR_FAULT, 16'hffff);
    rd_chk(FSR_ADDR_FAULT, {TB_PART_ID, 8'h00});
    i_host.wr_word(FSR_ADDR_STEP, 16'ha5e6);
    rd_chk(FSR_ADDR_STEP, 16'ha5e6);
    i_host.wr_word(8'h07, 16'h1234);
    rd_chk(8'h07, 16'h0000);
    // every stepping code against currents on both sides of each threshold
    for (int c = 0; c < 8; c++) begin
      i_host.wr_word(FSR_ADDR_STEP, {11'h000, 3'(c), 2'h0});
      foreach (ua_list[k]) begin
        @(negedge core_clk);
        led_current_ua = 16'(ua_list[k]);
        repeat (2) @(negedge core_clk);
        cmp_out({6'h00, freq_select}, {6'h00, exp_freq(3'(c), ua_list[k])});
      end
    end
    // every stagger code with dimming on, then staggered code with dimming off
    for (int m = 0; m < 5; m++) begin
      i_host.wr_word(FSR_ADDR_STEP, {14'h0000, (m == 4) ? 2'h1 : 2'(m)});
      run_stagger((m == 4) ? 2'h1 : 2'(m), m != 4);
    end
    stop_test;
  end
endmodule
